// ===== tec_pkg.sv
package tec_pkg;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [11:0] OFF_EVT_SELECT   = 12'h020;
    localparam logic [11:0] OFF_EVT_BEHAVE   = 12'h024;
    localparam logic [11:0] OFF_EXT_IN_SEL   = 12'h120;
    localparam logic [11:0] OFF_CAP_ID_A     = 12'h1E0;
    localparam logic [11:0] OFF_ARCH_ID      = 12'h1E4;
    localparam logic [11:0] OFF_PARAM_SIZE   = 12'h1E8;
    localparam logic [11:0] OFF_COMP_CAP_ID  = 12'hFC8;
    localparam logic [11:0] OFF_COMP_TYPE_ID = 12'hFCC;

    // ****************************************
    // event select layout
    // ****************************************
    localparam int NUM_EVENTS     = 4;
    localparam int EVT_FIELD_STEP = 8;
    localparam int EVT_NUM_LSB    = 0;
    localparam int EVT_KIND_BIT   = 7;
    localparam logic [31:0] EVT_SELECT_WMASK = 32'h8F8F_8F8F;

    // ****************************************
    // event behaviour layout
    // ****************************************
    localparam int BEH_KEEP_ALIVE_BIT = 12;
    localparam int BEH_TRIG_EN_BIT    = 11;
    localparam logic [31:0] EVT_BEHAVE_WMASK = 32'h0000_180F;

    // ****************************************
    // external input selector
    // ****************************************
    localparam int EXT_SEL_WIDTH  = 5;
    localparam int EXT_IN_LINES   = 30;
    localparam logic [31:0] EXT_IN_SEL_WMASK = 32'h0000_001F;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] EVT_SELECT_RST = 32'h0000_0000;
    localparam logic [31:0] EVT_BEHAVE_RST = 32'h0000_0000;
    localparam logic [4:0]  EXT_IN_SEL_RST = 5'h00;

    // ****************************************
    // capability id a fields
    // ****************************************
    localparam logic [1:0] CAP_RSV_HI           = 2'h0;
    localparam logic       COMMIT_MODE_FLAG     = 1'h1;
    localparam logic [4:0] TIMESTAMP_WIDTH_FIELD = 5'h08;
    localparam logic [6:0] CAP_RSV_MID          = 7'h00;
    localparam logic [1:0] Q_ELEMENT_SUPPORT    = 2'h0;
    localparam logic       Q_ELEMENT_FILTERING  = 1'h0;
    localparam logic [1:0] CONDITIONAL_RESULT_STYLE = 2'h0;
    localparam logic [1:0] EVENT_COUNT_MINUS_ONE = 2'h3;
    localparam logic       RETURN_STACK_SUPPORT = 1'h1;
    localparam logic       CAP_RSV_B8           = 1'h0;
    localparam logic       INSTR_CYCLE_COUNT_SUPPORT = 1'h1;
    localparam logic       CONDITIONAL_TRACE_SUPPORT = 1'h0;
    localparam logic       BRANCH_BROADCAST_SUPPORT  = 1'h1;
    localparam logic [1:0] DATA_TRACE_SUPPORT   = 2'h0;
    localparam logic [1:0] LOAD_STORE_P0_SUPPORT = 2'h0;
    localparam logic       CAP_RSV_ONE          = 1'h1;

    // ****************************************
    // architecture id fields
    // ****************************************
    localparam logic [7:0] ARCH_RSV_ZERO = 8'h00;
    localparam logic [3:0] ARCH_RSV_ONES = 4'hF;

    // ****************************************
    // component ids
    // ****************************************
    localparam logic [31:0] COMP_CAP_ID_VAL = 32'h0000_0000;
    localparam logic [23:0] TYPE_RSV_ZERO   = 24'h00_0000;
    localparam logic [3:0]  TYPE_SUB_CORE   = 4'h1;
    localparam logic [3:0]  TYPE_MAIN_SRC   = 4'h3;
    localparam logic [31:0] UNMAPPED_VAL    = 32'h0000_0000;

endpackage

// ===== tec_event_pick.sv
`timescale 1ns/1ps

module tec_event_pick (
    // selection
    input  wire logic       resource_kind,
    input  wire logic [3:0] resource_number,
    // resource sources
    input  wire logic [15:0] single_res,
    input  wire logic [7:0]  pair_res,
    // result
    output logic            event_hit
);

    // ****************************************
    // single or paired resource
    // ****************************************
    always_comb
    begin
        if (resource_kind)
            event_hit = pair_res[resource_number[2:0]];
        else
            event_hit = single_res[resource_number];
    end

endmodule

// ===== tec_regs.sv
`timescale 1ns/1ps

module tec_regs #(
    parameter logic [7:0]  DESIGNER_CODE   = 8'h5A,  // arbitrary value
    parameter logic [3:0]  ARCH_VERSION_HI = 4'h1,   // arbitrary value
    parameter logic [3:0]  ARCH_VERSION_LO = 4'h0,   // arbitrary value
    parameter logic [3:0]  IMPL_REVISION   = 4'h1,   // arbitrary value
    parameter logic [31:0] PARAM_SIZE_VAL  = 32'h0000_0000
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        CE,
    // debug register port
    input  wire logic        DBG_SEL,
    input  wire logic        DBG_WRITE,
    input  wire logic [11:0] DBG_ADDR,
    input  wire logic [31:0] DBG_WDATA,
    output logic [31:0]      DBG_RDATA,
    output logic             DBG_READY,
    // resource inputs
    input  wire logic [15:0] RESOURCE_IN,
    input  wire logic [7:0]  PAIR_IN,
    input  wire logic [29:0] EXT_IN,
    input  wire logic        LOW_POWER,
    input  wire logic        TRIG_REQ,
    // event outputs
    output logic [3:0]       EVENT_OUT,
    output logic [3:0]       EVENT_ELEM,
    output logic             ATB_TRIG,
    output logic             EXT_RESOURCE0
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [29:0] ext_meta;
        logic [29:0] ext_sync;
        logic [31:0] evt_select;
        logic [31:0] evt_behave;
        logic [4:0]  ext_sel;
        logic [31:0] rdata;
        logic        ready;
        logic [3:0]  event_out;
        logic [3:0]  event_elem;
        logic        atb_trig;
        logic        ext_res0;
    } tec_state_t;

    tec_state_t st_reg;
    tec_state_t st_next;

    logic [3:0] event_hit;
    logic       events_live;

    // ****************************************
    // read decode
    // ****************************************
    function automatic logic [31:0] read_word(
        input logic [11:0] addr,
        input logic [31:0] sel_r,
        input logic [31:0] beh_r,
        input logic [4:0]  ext_r
    );
        logic [31:0] w;
        w = tec_pkg::UNMAPPED_VAL;
        case (addr)
            tec_pkg::OFF_EVT_SELECT:
                w = sel_r & tec_pkg::EVT_SELECT_WMASK;
            tec_pkg::OFF_EVT_BEHAVE:
                w = beh_r & tec_pkg::EVT_BEHAVE_WMASK;
            tec_pkg::OFF_EXT_IN_SEL:
                w = {27'h000_0000, ext_r};
            tec_pkg::OFF_CAP_ID_A:
                w = {tec_pkg::CAP_RSV_HI,
                     tec_pkg::COMMIT_MODE_FLAG,
                     tec_pkg::TIMESTAMP_WIDTH_FIELD,
                     tec_pkg::CAP_RSV_MID,
                     tec_pkg::Q_ELEMENT_SUPPORT,
                     tec_pkg::Q_ELEMENT_FILTERING,
                     tec_pkg::CONDITIONAL_RESULT_STYLE,
                     tec_pkg::EVENT_COUNT_MINUS_ONE,
                     tec_pkg::RETURN_STACK_SUPPORT,
                     tec_pkg::CAP_RSV_B8,
                     tec_pkg::INSTR_CYCLE_COUNT_SUPPORT,
                     tec_pkg::CONDITIONAL_TRACE_SUPPORT,
                     tec_pkg::BRANCH_BROADCAST_SUPPORT,
                     tec_pkg::DATA_TRACE_SUPPORT,
                     tec_pkg::LOAD_STORE_P0_SUPPORT,
                     tec_pkg::CAP_RSV_ONE};
            tec_pkg::OFF_ARCH_ID:
                w = {DESIGNER_CODE,
                     tec_pkg::ARCH_RSV_ZERO,
                     tec_pkg::ARCH_RSV_ONES,
                     ARCH_VERSION_HI,
                     ARCH_VERSION_LO,
                     IMPL_REVISION};
            tec_pkg::OFF_PARAM_SIZE:
                w = PARAM_SIZE_VAL;
            tec_pkg::OFF_COMP_CAP_ID:
                w = tec_pkg::COMP_CAP_ID_VAL;
            tec_pkg::OFF_COMP_TYPE_ID:
                w = {tec_pkg::TYPE_RSV_ZERO,
                     tec_pkg::TYPE_SUB_CORE,
                     tec_pkg::TYPE_MAIN_SRC};
            default:
                w = tec_pkg::UNMAPPED_VAL;
        endcase
        return w;
    endfunction

    // ****************************************
    // event selectors
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < tec_pkg::NUM_EVENTS; gi = gi + 1)
        begin : g_evt
            localparam int BASE = gi * tec_pkg::EVT_FIELD_STEP;
            tec_event_pick u_pick (
                .resource_kind   (st_reg.evt_select[BASE +
                                   tec_pkg::EVT_KIND_BIT]),
                .resource_number (st_reg.evt_select[BASE +
                                   tec_pkg::EVT_NUM_LSB +: 4]),
                .single_res      (RESOURCE_IN),
                .pair_res        (PAIR_IN),
                .event_hit       (event_hit[gi])
            );
        end
    endgenerate

    // low power stops events unless kept alive
    assign events_live = !LOW_POWER ||
        st_reg.evt_behave[tec_pkg::BEH_KEEP_ALIVE_BIT];

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.ext_meta = EXT_IN;
        st_next.ext_sync = st_reg.ext_meta;
        st_next.ready = 1'b0;
        if (DBG_SEL)
        begin
            st_next.ready = 1'b1;
            if (DBG_WRITE)
            begin
                case (DBG_ADDR)
                    tec_pkg::OFF_EVT_SELECT:
                        st_next.evt_select =
                            DBG_WDATA & tec_pkg::EVT_SELECT_WMASK;
                    tec_pkg::OFF_EVT_BEHAVE:
                        st_next.evt_behave =
                            DBG_WDATA & tec_pkg::EVT_BEHAVE_WMASK;
                    tec_pkg::OFF_EXT_IN_SEL:
                        st_next.ext_sel =
                            DBG_WDATA[tec_pkg::EXT_SEL_WIDTH-1:0];
                    default:
                        st_next.ext_sel = st_reg.ext_sel;
                endcase
            end
            else
            begin
                st_next.rdata = read_word(DBG_ADDR, st_reg.evt_select,
                    st_reg.evt_behave, st_reg.ext_sel);
            end
        end
        st_next.event_out = events_live ? event_hit : 4'h0;
        st_next.event_elem = (events_live ? event_hit : 4'h0) &
            st_reg.evt_behave[3:0];
        st_next.atb_trig = TRIG_REQ &&
            st_reg.evt_behave[tec_pkg::BEH_TRIG_EN_BIT];
        if (st_reg.ext_sel < 5'(tec_pkg::EXT_IN_LINES))
            st_next.ext_res0 = st_reg.ext_sync[st_reg.ext_sel];
        else
            st_next.ext_res0 = 1'b0;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_reg <= '0;
            st_reg.evt_select <= tec_pkg::EVT_SELECT_RST;
            st_reg.evt_behave <= tec_pkg::EVT_BEHAVE_RST;
            st_reg.ext_sel <= tec_pkg::EXT_IN_SEL_RST;
        end
        else if (CE)
        begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign DBG_RDATA     = st_reg.rdata;
    assign DBG_READY     = st_reg.ready;
    assign EVENT_OUT     = st_reg.event_out;
    assign EVENT_ELEM    = st_reg.event_elem;
    assign ATB_TRIG      = st_reg.atb_trig;
    assign EXT_RESOURCE0 = st_reg.ext_res0;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    logic rd_req;
    assign rd_req = DBG_SEL && !DBG_WRITE && CE;

    comp_cap_read_a: assert property (
        rd_req && DBG_ADDR == tec_pkg::OFF_COMP_CAP_ID |=>
        DBG_READY && DBG_RDATA == 32'h0000_0000)
        else $error("capability id read wrong");

    comp_type_read_a: assert property (
        rd_req && DBG_ADDR == tec_pkg::OFF_COMP_TYPE_ID |=>
        DBG_RDATA == 32'h0000_0013)
        else $error("component type read wrong");

    cap_id_read_a: assert property (
        rd_req && DBG_ADDR == tec_pkg::OFF_CAP_ID_A |=>
        DBG_RDATA == 32'h2800_0EA1)
        else $error("capability a read wrong");

    arch_id_read_a: assert property (
        rd_req && DBG_ADDR == tec_pkg::OFF_ARCH_ID |=>
        DBG_RDATA[23:12] == 12'h00F)
        else $error("architecture id reserved bits wrong");

    sel_write_back_a: assert property (
        DBG_SEL && DBG_WRITE && CE &&
        DBG_ADDR == tec_pkg::OFF_EVT_SELECT
        ##1 CE && !DBG_SEL
        ##1 rd_req && DBG_ADDR == tec_pkg::OFF_EVT_SELECT |=>
        DBG_RDATA == ($past(DBG_WDATA, 3) & 32'h8F8F_8F8F))
        else $error("event select read back wrong");

    beh_reserved_a: assert property (
        rd_req && DBG_ADDR == tec_pkg::OFF_EVT_BEHAVE |=>
        DBG_RDATA[31:13] == 19'h0 && DBG_RDATA[10:4] == 7'h0)
        else $error("behaviour reserved bits not zero");

    trig_gate_a: assert property (
        CE && !st_reg.evt_behave[11] |=> !ATB_TRIG)
        else $error("trigger while disabled");

    elem_enable_a: assert property (
        CE |=> (EVENT_ELEM & ~$past(st_reg.evt_behave[3:0])) == 4'h0)
        else $error("event element while disabled");

    low_power_a: assert property (
        CE && LOW_POWER && !st_reg.evt_behave[12] |=> EVENT_OUT == 4'h0)
        else $error("events live in low power");

    single_pick_a: assert property (
        CE && !LOW_POWER && !st_reg.evt_select[7] |=>
        EVENT_OUT[0] == $past(RESOURCE_IN[st_reg.evt_select[3:0]]))
        else $error("single resource pick wrong");

    pair_pick_a: assert property (
        CE && !LOW_POWER && st_reg.evt_select[7] |=>
        EVENT_OUT[0] == $past(PAIR_IN[st_reg.evt_select[2:0]]))
        else $error("pair resource pick wrong");

    ext_pick_a: assert property (
        CE && st_reg.ext_sel == 5'h00 ##1 CE && st_reg.ext_sel == 5'h00
        ##1 CE && st_reg.ext_sel == 5'h00 |=>
        EXT_RESOURCE0 == $past(EXT_IN[0], 3))
        else $error("external input pick wrong");

    ready_pulse_a: assert property (
        CE |=> DBG_READY == $past(DBG_SEL))
        else $error("ready does not follow request");

    ext_sel_zero_a: assert property (
        rd_req && DBG_ADDR == tec_pkg::OFF_EXT_IN_SEL |=>
        DBG_RDATA[31:5] == 27'h0)
        else $error("selector reserved bits not zero");

    sel_reserved_a: assert property (
        rd_req && DBG_ADDR == tec_pkg::OFF_EVT_SELECT |=>
        (DBG_RDATA & 32'h7070_7070) == 32'h0000_0000)
        else $error("select reserved bits not zero");

    trig_follow_a: assert property (
        CE && st_reg.evt_behave[11] |=> ATB_TRIG == $past(TRIG_REQ))
        else $error("trigger lost while enabled");

    keep_alive_a: assert property (
        CE && LOW_POWER && st_reg.evt_behave[12] &&
        !st_reg.evt_select[7] |=>
        EVENT_OUT[0] == $past(RESOURCE_IN[st_reg.evt_select[3:0]]))
        else $error("kept-alive event lost");

    event3_pick_a: assert property (
        CE && !LOW_POWER && st_reg.evt_select[31] |=>
        EVENT_OUT[3] == $past(PAIR_IN[st_reg.evt_select[26:24]]))
        else $error("event three pair pick wrong");

    ext_range_a: assert property (
        CE && st_reg.ext_sel >= 5'h1E |=> !EXT_RESOURCE0)
        else $error("external input beyond bus");

    trig_seen_c: cover property (ATB_TRIG);
    ext_seen_c: cover property (EXT_RESOURCE0);
    elem_seen_c: cover property (EVENT_ELEM != 4'h0);
    pair_event_c: cover property (st_reg.evt_select[31] && EVENT_OUT[3]);
    keep_alive_c: cover property (LOW_POWER && st_reg.evt_behave[12]
        ##1 EVENT_OUT != 4'h0);

endmodule

// ===== tec_dbg_agent.sv
`timescale 1ns/1ps

module tec_dbg_agent (
    // clock
    input  wire logic        clk,
    // request
    output logic             sel,
    output logic             write,
    output logic [11:0]      addr,
    output logic [31:0]      wdata,
    // answer
    input  wire logic [31:0] rdata,
    input  wire logic        ready
);
    initial
    begin
        sel   = 1'b0;
        write = 1'b0;
        addr  = 12'h000;
        wdata = 32'h0000_0000;
    end

    // one word access, request held until the edge that sees ready
    task automatic access(input logic w, input logic [11:0] a,
                          input logic [31:0] d, output logic [31:0] q,
                          output logic ok);
        ok    = 1'b0;
        q     = 32'h0000_0000;
        sel   = 1'b1;
        write = w;
        addr  = a;
        wdata = d;
        for (int i = 0; i < 8 && !ok; i++)
        begin
            @(posedge clk);
            if (ready === 1'b1)
            begin
                ok = 1'b1;
                q  = rdata;
            end
        end
        #1;
        // released sel, addr and wdata never keep the old value; write keeps it
        sel   = 1'b0;
        addr  = ~a;
        wdata = ~d;
        // one idle edge so the next request never sees a stale ready
        @(posedge clk);
        #1;
    endtask
endmodule

// ===== tec_regs_test.sv
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        tests_run++; \
        if ((a) !== (e)) \
        begin \
            n_errors++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
        end \
    end

module tec_regs_test;
    // ****************************************
    // identification values, all arbitrary
    // ****************************************
    localparam logic [7:0]  DES_CODE = 8'h3C;
    localparam logic [3:0]  VER_HI   = 4'h3;
    localparam logic [3:0]  VER_LO   = 4'h1;
    localparam logic [3:0]  REV      = 4'h7;
    localparam logic [31:0] PSIZE    = 32'h0123_4567;

    logic        clk;
    logic        rst_b;
    logic        ce;
    logic        d_sel;
    logic        d_wr;
    logic [11:0] d_addr;
    logic [31:0] d_wdata;
    logic [31:0] d_rdata;
    logic        d_ready;
    logic [15:0] res_in;
    logic [7:0]  pair_in;
    logic [29:0] ext_in;
    logic        low_pw;
    logic        trig;
    logic [3:0]  ev_out;
    logic [3:0]  ev_elem;
    logic        atb;
    logic        ext_res0;
    int          n_errors  = 0;
    int          tests_run = 0;

    tec_regs #(
        .DESIGNER_CODE  (DES_CODE),
        .ARCH_VERSION_HI(VER_HI),
        .ARCH_VERSION_LO(VER_LO),
        .IMPL_REVISION  (REV),
        .PARAM_SIZE_VAL (PSIZE)
    ) i_tec_regs (
        .CLK(clk), .RST_B(rst_b), .CE(ce),
        .DBG_SEL(d_sel), .DBG_WRITE(d_wr), .DBG_ADDR(d_addr),
        .DBG_WDATA(d_wdata), .DBG_RDATA(d_rdata), .DBG_READY(d_ready),
        .RESOURCE_IN(res_in), .PAIR_IN(pair_in), .EXT_IN(ext_in),
        .LOW_POWER(low_pw), .TRIG_REQ(trig), .EVENT_OUT(ev_out),
        .EVENT_ELEM(ev_elem), .ATB_TRIG(atb), .EXT_RESOURCE0(ext_res0)
    );

    tec_dbg_agent i_tec_dbg_agent (
        .clk(clk), .sel(d_sel), .write(d_wr), .addr(d_addr),
        .wdata(d_wdata), .rdata(d_rdata), .ready(d_ready)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        logic ok;
        i_tec_dbg_agent.access(w, a, d, q, ok);
        if (ok !== 1'b1)
        begin
            n_errors++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_rw();
        rd(12'h020, 32'h0000_0000);
        rd(12'h024, 32'h0000_0000);
        rd(12'h120, 32'h0000_0000);
        wr(12'h020, 32'hFFFF_FFFF);
        rd(12'h020, 32'h8F8F_8F8F);
        wr(12'h024, 32'hFFFF_FFFF);
        rd(12'h024, 32'h0000_180F);
        wr(12'h120, 32'hFFFF_FFFF);
        rd(12'h120, 32'h0000_001F);
    endtask

    task automatic t_ids();
        rd(12'h1E0, 32'h2800_0EA1);
        rd(12'h1E0, 32'h2800_0EA1);
        rd(12'h1E4, {DES_CODE, 8'h00, 4'hF, VER_HI, VER_LO, REV});
        rd(12'h1E4, {DES_CODE, 8'h00, 4'hF, VER_HI, VER_LO, REV});
        rd(12'h1E8, PSIZE);
        rd(12'hFC8, 32'h0000_0000);
        rd(12'hFCC, 32'h0000_0013);
        wr(12'h1E0, 32'h0000_0000);
        wr(12'hFC8, 32'hFFFF_FFFF);
        wr(12'hFCC, 32'hFFFF_FFFF);
        rd(12'h1E0, 32'h2800_0EA1);
        rd(12'hFC8, 32'h0000_0000);
        rd(12'hFCC, 32'h0000_0013);
        rd(12'h300, 32'h0000_0000);
    endtask

    task automatic t_single();
        for (int r = 0; r < 16; r++)
        begin
            wr(12'h020, {4{4'h0, r[3:0]}});
            res_in = 16'h0001 << r;
            cyc(1);
            `CHK(ev_out, 4'hF)
            res_in = ~(16'h0001 << r);
            cyc(1);
            `CHK(ev_out, 4'h0)
        end
        wr(12'h020, 32'h0C08_0400);
        res_in = 16'h0110;
        cyc(1);
        `CHK(ev_out, 4'h6)
    endtask

    task automatic t_pair();
        res_in = 16'hFFFF;
        for (int p = 0; p < 8; p++)
        begin
            wr(12'h020, {4{5'h11, p[2:0]}});
            pair_in = 8'h01 << p;
            cyc(1);
            `CHK(ev_out, 4'hF)
            pair_in = ~(8'h01 << p);
            cyc(1);
            `CHK(ev_out, 4'h0)
        end
    endtask

    task automatic t_elem();
        wr(12'h020, 32'h0000_0000);
        wr(12'h024, 32'h0000_0005);
        res_in = 16'h0001;
        cyc(1);
        `CHK({ev_out, ev_elem}, 8'hF5)
        low_pw = 1'b1;
        cyc(1);
        `CHK({ev_out, ev_elem}, 8'h00)
        wr(12'h024, 32'h0000_100A);
        cyc(1);
        `CHK({ev_out, ev_elem}, 8'hFA)
        low_pw = 1'b0;
    endtask

    task automatic t_trig();
        trig = 1'b1;
        wr(12'h024, 32'h0000_0000);
        cyc(1);
        `CHK(atb, 1'b0)
        wr(12'h024, 32'h0000_0800);
        cyc(1);
        `CHK(atb, 1'b1)
        trig = 1'b0;
        cyc(1);
        `CHK(atb, 1'b0)
    endtask

    task automatic t_ext();
        for (int s = 0; s < 30; s++)
        begin
            wr(12'h120, {27'h0, s[4:0]});
            ext_in = 30'h1 << s;
            cyc(3);
            `CHK(ext_res0, 1'b1)
            ext_in = ~(30'h1 << s);
            cyc(3);
            `CHK(ext_res0, 1'b0)
        end
        wr(12'h120, 32'h0000_001E);
        ext_in = 30'h3FFF_FFFF;
        cyc(3);
        `CHK(ext_res0, 1'b0)
    endtask

    task automatic t_freeze();
        wr(12'h020, 32'h0000_0000);
        low_pw = 1'b0;
        res_in = 16'h0001;
        cyc(1);
        `CHK(ev_out, 4'hF)
        ce     = 1'b0;
        res_in = 16'h0000;
        cyc(2);
        `CHK(ev_out, 4'hF)
        ce = 1'b1;
        cyc(1);
        `CHK(ev_out, 4'h0)
    endtask

    task automatic t_reset();
        wr(12'h020, 32'hFFFF_FFFF);
        wr(12'h024, 32'hFFFF_FFFF);
        rst_b = 1'b0;
        cyc(2);
        `CHK({ev_out, ev_elem, atb, ext_res0}, 10'h000)
        rst_b = 1'b1;
        rd(12'h020, 32'h0000_0000);
        rd(12'h024, 32'h0000_0000);
        rd(12'h120, 32'h0000_0000);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst_b   = 1'b0;
        ce      = 1'b1;
        res_in  = 16'h0000;
        pair_in = 8'h00;
        ext_in  = 30'h0000_0000;
        low_pw  = 1'b0;
        trig    = 1'b0;
        cyc(20);
        rst_b = 1'b1;
        t_rw();
        t_ids();
        t_single();
        t_pair();
        t_elem();
        t_trig();
        t_ext();
        t_freeze();
        t_reset();
        give_verdict();
    end
endmodule
